// *** logic/obcd_loader.sv ***
`timescale 1ns/100ps
`include "obcd_defines.svh"

// Overview of operation
// - slow_osc_cpu_allow 1 offers slow internal oscillator as cpu clock, 0 does not.
// - indep_dog_hw_start 1 starts independent watchdog by hardware, 0 leaves to software.
// - window_dog_hw_start 1 starts window watchdog by hardware, 0 leaves to software.
// - window_dog_halt_reset 1 resets on halt entry while window watchdog active.
// - ext_clock_select 1 means driven clock on input pin, 0 means crystal.
// - autowake_clock_select 0 clocks wakeup from slow osc, 1 from prescaled external.
// - autowake_prescale 00/01/10/11 divides 24/16/8/4 MHz down to 128 kHz.
// - crystal_settle_count e1/d2/b4/00 gives 0.5/8/128/2048 oscillator cycles.
// - temp_unprotect_ctrl 0101 disables temporary unprotection; other values enable it.
// - wait state bit 1 adds one wait state to flash and eeprom reads.
module obcd_loader
  import obcd_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // option storage read port
  output logic [3:0]       opt_addr,
  output logic             opt_rd,
  input  wire obcd_byte_t  opt_data,
  input  wire logic        opt_valid,
  // run-time request from the watchdog path
  input  wire logic        window_dog_active,
  input  wire logic        halt_entry,
  // load status
  output logic             cfg_loaded,
  output logic             units_rst_n,
  // clock controller
  output logic             slow_osc_cpu_allow,
  output logic             ext_clock_select,
  output logic             osc_output_pin_drive,
  output logic [11:0]      crystal_settle_cycles,
  output logic             crystal_settle_half,
  output logic             crystal_settle_code_ok,
  // watchdogs
  output logic             indep_dog_hw_start,
  output logic             window_dog_hw_start,
  output logic             window_dog_halt_reset,
  output logic             halt_reset_req,
  // auto wakeup
  output logic             autowake_clock_select,
  output logic [1:0]       autowake_prescale,
  output logic [7:0]       autowake_divide,
  // memory protection and flash
  output logic [3:0]       temp_unprotect_ctrl,
  output logic             temp_unprotect_en,
  output logic [31:0]      temp_unprotect_key,
  output logic             temp_unprotect_key_ok,
  output logic             flash_wait_state
);

  // ----------------------------------------
  // load sequencer
  // ----------------------------------------
  obcd_state_t               state_reg;
  obcd_state_t               state_next;
  logic [`OBCD_IDX_W-1:0]    idx_reg;
  logic [`OBCD_IDX_W-1:0]    idx_next;
  obcd_byte_t                img_reg [0:8];
  obcd_byte_t                img_next [0:8];
  logic                      hrst_reg;
  logic                      hrst_next;

  function automatic logic key_good(input obcd_byte_t k);
    key_good = (k != `OBCD_KEY_LOW_BAD) && (k != `OBCD_KEY_HIGH_BAD);
  endfunction

  always_comb
  begin
    state_next = state_reg;
    idx_next   = idx_reg;
    for (int i = 0; i < 9; i++)
      img_next[i] = img_reg[i];
    case (state_reg)
      OBCD_IDLE: state_next = OBCD_READ;
      OBCD_READ: state_next = OBCD_WAIT;
      OBCD_WAIT:
      begin
        if (opt_valid)
        begin
          img_next[idx_reg] = opt_data;
          if (idx_reg == `OBCD_NUM_BYTES - 4'h1)
            state_next = OBCD_DONE;
          else
          begin
            idx_next   = idx_reg + 4'h1;
            state_next = OBCD_READ;
          end
        end
      end
      // settings frozen until the next reset
      OBCD_DONE: state_next = OBCD_DONE;
      default:   state_next = OBCD_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= OBCD_IDLE;
      idx_reg   <= '0;
      for (int i = 0; i < 9; i++)
        img_reg[i] <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      idx_reg   <= idx_next;
      for (int i = 0; i < 9; i++)
        img_reg[i] <= img_next[i];
    end
  end

  assign opt_addr    = idx_reg;
  assign opt_rd      = (state_reg == OBCD_READ);
  assign cfg_loaded  = (state_reg == OBCD_DONE);
  // dependent units held in reset until image complete
  assign units_rst_n = (state_reg == OBCD_DONE);

  // ----------------------------------------
  // field decode
  // ----------------------------------------
  // outputs read zero from reset and follow each byte as it loads; only osc_output_pin_drive and temp_unprotect_en wait for cfg_loaded
  assign slow_osc_cpu_allow   = img_reg[`OBCD_IDX_MISC][`OBCD_BIT_SLOW_OSC];
  assign indep_dog_hw_start   = img_reg[`OBCD_IDX_MISC][`OBCD_BIT_INDEP_HW];
  assign window_dog_hw_start  = img_reg[`OBCD_IDX_MISC][`OBCD_BIT_WIN_HW];
  assign window_dog_halt_reset = img_reg[`OBCD_IDX_MISC][`OBCD_BIT_WIN_HALT];
  assign ext_clock_select     = img_reg[`OBCD_IDX_CLK][`OBCD_BIT_EXT_CLK];
  // crystal needs the output pin, external clock leaves it free
  assign osc_output_pin_drive = cfg_loaded & ~ext_clock_select;
  assign autowake_clock_select = img_reg[`OBCD_IDX_CLK][`OBCD_BIT_WAKE_SEL];
  assign autowake_prescale    =
    img_reg[`OBCD_IDX_CLK][`OBCD_PRESCALE_HI:`OBCD_PRESCALE_LO];
  assign temp_unprotect_ctrl  = img_reg[`OBCD_IDX_UNPROT][3:0];
  assign temp_unprotect_en    = cfg_loaded && (temp_unprotect_ctrl != `OBCD_UNPROT_OFF);
  assign flash_wait_state     = img_reg[`OBCD_IDX_WAIT][`OBCD_BIT_WAIT];

  // ----------------------------------------
  // registered decode
  // ----------------------------------------
  // decoded from the next image so these move in step with the image bytes
  logic [1:0]                prescale_next;
  logic [7:0]                divide_reg;
  logic [7:0]                divide_next;
  logic [11:0]               settle_cyc_reg;
  logic [11:0]               settle_cyc_next;
  logic                      settle_half_reg;
  logic                      settle_half_next;
  logic                      settle_ok_reg;
  logic                      settle_ok_next;

  always_comb
  begin
    prescale_next = img_next[`OBCD_IDX_CLK][`OBCD_PRESCALE_HI:`OBCD_PRESCALE_LO];
    case (prescale_next)
      2'b00:   divide_next = `OBCD_DIV_24M;
      2'b01:   divide_next = `OBCD_DIV_16M;
      2'b10:   divide_next = `OBCD_DIV_8M;
      default: divide_next = `OBCD_DIV_4M;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      // reset values decode an all-zero image
      divide_reg      <= `OBCD_DIV_24M;
      settle_cyc_reg  <= `OBCD_CYC_2048;
      settle_half_reg <= 1'b0;
      settle_ok_reg   <= 1'b1;
    end
    else
    begin
      divide_reg      <= divide_next;
      settle_cyc_reg  <= settle_cyc_next;
      settle_half_reg <= settle_half_next;
      settle_ok_reg   <= settle_ok_next;
    end
  end

  assign autowake_divide        = divide_reg;
  assign crystal_settle_cycles  = settle_cyc_reg;
  assign crystal_settle_half    = settle_half_reg;
  assign crystal_settle_code_ok = settle_ok_reg;

  // ----------------------------------------
  // unprotect keys
  // ----------------------------------------
  logic [3:0] key_ok;
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_key
      assign temp_unprotect_key[8*g +: 8] = img_reg[`OBCD_IDX_KEY0 + g];
      // flag keys the programmer left illegal
      assign key_ok[g] = key_good(img_reg[`OBCD_IDX_KEY0 + g]);
    end
  endgenerate
  assign temp_unprotect_key_ok = &key_ok;

  // ----------------------------------------
  // halt reset request
  // ----------------------------------------
  always_comb
  begin
    hrst_next = cfg_loaded && window_dog_halt_reset
                && window_dog_active && halt_entry;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      hrst_reg <= 1'b0;
    else
      hrst_reg <= hrst_next;
  end
  assign halt_reset_req = hrst_reg;

  // ----------------------------------------
  // crystal settle decode
  // ----------------------------------------
  obcd_settle_decode u_settle
  (
    .code       (img_next[`OBCD_IDX_SETTLE]),
    .cycles     (settle_cyc_next),
    .half_cycle (settle_half_next),
    .code_valid (settle_ok_next)
  );

endmodule

// *** inc/obcd_defines.svh ***
`ifndef OBCD_DEFINES_SVH
`define OBCD_DEFINES_SVH

// option byte indices within the stored image
`define OBCD_IDX_MISC      4'h0
`define OBCD_IDX_CLK       4'h1
`define OBCD_IDX_SETTLE    4'h2
`define OBCD_IDX_UNPROT    4'h3
`define OBCD_IDX_WAIT      4'h4
`define OBCD_IDX_KEY0      4'h5
`define OBCD_NUM_BYTES     4'h9
`define OBCD_IDX_W         4

// misc byte field positions
`define OBCD_BIT_SLOW_OSC  0
`define OBCD_BIT_INDEP_HW  1
`define OBCD_BIT_WIN_HW    2
`define OBCD_BIT_WIN_HALT  3
// clock byte and wait byte field positions
`define OBCD_BIT_EXT_CLK   3
`define OBCD_BIT_WAKE_SEL  2
`define OBCD_PRESCALE_HI   1
`define OBCD_PRESCALE_LO   0
`define OBCD_BIT_WAIT      0

// crystal settle encodings and cycle counts
`define OBCD_SETTLE_HALF   8'he1
`define OBCD_SETTLE_8      8'hd2
`define OBCD_SETTLE_128    8'hb4
`define OBCD_SETTLE_2048   8'h00
`define OBCD_CYC_HALF      12'h000
`define OBCD_CYC_8         12'h008
`define OBCD_CYC_128       12'h080
`define OBCD_CYC_2048      12'h800

// temporary unprotection
`define OBCD_UNPROT_OFF    4'h5
`define OBCD_KEY_LOW_BAD   8'h00
`define OBCD_KEY_HIGH_BAD  8'hff

// autowake prescale divide ratios to 128 kHz
`define OBCD_DIV_24M       8'hbb
`define OBCD_DIV_16M       8'h7d
`define OBCD_DIV_8M        8'h3e
`define OBCD_DIV_4M        8'h1f

`endif

// *** inc/obcd_pkg.sv ***
package obcd_pkg;

  typedef enum logic [3:0]
  {
    OBCD_IDLE = 4'b0001,
    OBCD_READ = 4'b0010,
    OBCD_WAIT = 4'b0100,
    OBCD_DONE = 4'b1000
  } obcd_state_t;

  typedef logic [7:0] obcd_byte_t;

endpackage

// *** logic/obcd_settle_decode.sv ***
`timescale 1ns/100ps
`include "obcd_defines.svh"

module obcd_settle_decode
  import obcd_pkg::*;
(
  // stored settle byte
  input  wire obcd_byte_t  code,
  // decoded wait
  output logic [11:0]      cycles,
  output logic             half_cycle,
  output logic             code_valid
);

  // ----------------------------------------
  // settle count decode
  // ----------------------------------------
  always_comb
  begin
    half_cycle = 1'b0;
    code_valid = 1'b1;
    case (code)
      `OBCD_SETTLE_HALF:
      begin
        cycles     = `OBCD_CYC_HALF;
        half_cycle = 1'b1;
      end
      `OBCD_SETTLE_8:    cycles = `OBCD_CYC_8;
      `OBCD_SETTLE_128:  cycles = `OBCD_CYC_128;
      `OBCD_SETTLE_2048: cycles = `OBCD_CYC_2048;
      default:
      begin
        // unknown code: take the longest, safest wait
        cycles     = `OBCD_CYC_2048;
        code_valid = 1'b0;
      end
    endcase
  end

endmodule

// *** verif/obcd_loader_props.sv ***
`timescale 1ns/100ps
module obcd_loader_props
(
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rstn,
  // load side
  input wire logic       opt_rd,
  input wire logic       cfg_loaded,
  input wire logic       units_rst_n,
  input wire logic       window_dog_active,
  input wire logic       halt_entry,
  // decoded settings
  input wire logic       slow_osc_cpu_allow,
  input wire logic       indep_dog_hw_start,
  input wire logic       window_dog_hw_start,
  input wire logic       window_dog_halt_reset,
  input wire logic       halt_reset_req,
  input wire logic       ext_clock_select,
  input wire logic       osc_output_pin_drive,
  input wire logic       autowake_clock_select,
  input wire logic [1:0] autowake_prescale,
  input wire logic [7:0] autowake_divide,
  input wire logic [3:0] temp_unprotect_ctrl,
  input wire logic       temp_unprotect_en,
  input wire logic       flash_wait_state
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  property p_loaded_holds;
    cfg_loaded |=> cfg_loaded;
  endproperty
  a_loaded_holds: assert property (p_loaded_holds) else $error("load flag dropped");
  property p_units;
    units_rst_n == cfg_loaded;
  endproperty
  a_units: assert property (p_units) else $error("unit release mismatch");
  property p_rd_pulse;
    opt_rd |=> !opt_rd;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe too long");
  // one check for the static bits except window_dog_halt_reset, since they share one hold rule
  property p_cfg_stable;
    $past(cfg_loaded) |-> $stable({slow_osc_cpu_allow, indep_dog_hw_start,
      window_dog_hw_start, ext_clock_select, autowake_clock_select, flash_wait_state});
  endproperty
  a_cfg_stable: assert property (p_cfg_stable) else $error("setting moved");
  property p_halt_req;
    cfg_loaded && window_dog_halt_reset && window_dog_active && halt_entry |=> halt_reset_req;
  endproperty
  a_halt_req: assert property (p_halt_req) else $error("halt reset missing");
  property p_no_halt_req;
    !window_dog_halt_reset |=> !halt_reset_req;
  endproperty
  a_no_halt_req: assert property (p_no_halt_req) else $error("halt reset unwanted");
  property p_osc_drive;
    osc_output_pin_drive == (cfg_loaded && !ext_clock_select);
  endproperty
  a_osc_drive: assert property (p_osc_drive) else $error("osc drive wrong");
  property p_divide;
    cfg_loaded |-> autowake_divide == (autowake_prescale == 2'h0 ? 8'hbb :
      autowake_prescale == 2'h1 ? 8'h7d : autowake_prescale == 2'h2 ? 8'h3e : 8'h1f);
  endproperty
  a_divide: assert property (p_divide) else $error("wakeup divide wrong");
  property p_unprot;
    temp_unprotect_en == (cfg_loaded && temp_unprotect_ctrl != 4'h5);
  endproperty
  a_unprot: assert property (p_unprot) else $error("unprotect enable wrong");
endmodule

bind obcd_loader obcd_loader_props i_props (.sys_clk, .rstn, .opt_rd, .cfg_loaded,
  .units_rst_n, .window_dog_active, .halt_entry, .slow_osc_cpu_allow, .indep_dog_hw_start,
  .window_dog_hw_start, .window_dog_halt_reset, .halt_reset_req, .ext_clock_select,
  .osc_output_pin_drive, .autowake_clock_select, .autowake_prescale, .autowake_divide,
  .temp_unprotect_ctrl, .temp_unprotect_en, .flash_wait_state);

// *** verif/obcd_loader_tb_top.sv ***
`timescale 1ns/100ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module obcd_loader_tb_top
  import obcd_pkg::*;
;
  // ----------------
  // stimulus tables
  // ----------------
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  obcd_byte_t  opt_data = 8'h00;
  logic        opt_valid = 1'b0;
  logic        window_dog_active = 1'b0;
  logic        halt_entry = 1'b0;
  logic [3:0]  opt_addr;
  logic [11:0] crystal_settle_cycles;
  logic [31:0] temp_unprotect_key;
  logic [7:0]  autowake_divide;
  logic [1:0]  autowake_prescale;
  logic [3:0]  temp_unprotect_ctrl;
  logic        opt_rd, cfg_loaded, units_rst_n, slow_osc_cpu_allow, ext_clock_select;
  logic        osc_output_pin_drive, crystal_settle_half, crystal_settle_code_ok;
  logic        indep_dog_hw_start, window_dog_hw_start, window_dog_halt_reset;
  logic        halt_reset_req, autowake_clock_select, temp_unprotect_en;
  logic        temp_unprotect_key_ok, flash_wait_state;
  int          n_mismatch = 0;
  int          total_checks = 0;
  // keys avoid 00 and ff as the programmer must
  // last image: unknown settle code, halt with the window watchdog idle
  logic [7:0]  img [5][9] = '{
    '{8'h0f, 8'h08, 8'he1, 8'h05, 8'h01, 8'h11, 8'h22, 8'h33, 8'h44},
    '{8'h00, 8'h05, 8'hd2, 8'h0a, 8'h00, 8'h01, 8'h02, 8'h03, 8'hfe},
    '{8'h05, 8'h0e, 8'hb4, 8'h00, 8'h01, 8'h7f, 8'h80, 8'h5a, 8'ha5},
    '{8'h0a, 8'h07, 8'h00, 8'h04, 8'h00, 8'hc3, 8'h3c, 8'h99, 8'h66},
    '{8'h08, 8'h00, 8'h3c, 8'h0f, 8'h01, 8'h12, 8'h34, 8'h56, 8'h78}};
  logic [7:0]  div_exp [5] = '{8'hbb, 8'h7d, 8'h3e, 8'h1f, 8'hbb};
  logic [11:0] cyc_exp [5] = '{12'h000, 12'h008, 12'h080, 12'h800, 12'h800};

  obcd_loader i_dut (.sys_clk, .rstn, .opt_addr, .opt_rd, .opt_data, .opt_valid,
    .window_dog_active, .halt_entry, .cfg_loaded, .units_rst_n, .slow_osc_cpu_allow,
    .ext_clock_select, .osc_output_pin_drive, .crystal_settle_cycles, .crystal_settle_half,
    .crystal_settle_code_ok, .indep_dog_hw_start, .window_dog_hw_start,
    .window_dog_halt_reset, .halt_reset_req, .autowake_clock_select, .autowake_prescale,
    .autowake_divide, .temp_unprotect_ctrl, .temp_unprotect_en, .temp_unprotect_key,
    .temp_unprotect_key_ok, .flash_wait_state);

  always #4 sys_clk = ~sys_clk;

  task give_verdict;
    if (n_mismatch == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------
  // storage answers
  // ----------------
  // slow answer on purpose: valid comes one cycle after the strobe
  task load(input int k);
    int w;
    for (int i = 0; i < 9; i++)
    begin
      w = 0;
      while (opt_rd !== 1'b1 && w < 50)
      begin
        @(posedge sys_clk);
        #1;
        w++;
      end
      `CHK({opt_rd, opt_addr}, {1'b1, i[3:0]})
      @(posedge sys_clk);
      #1;
      opt_data = img[k][opt_addr];
      opt_valid = 1'b1;
      @(posedge sys_clk);
      #1;
      opt_valid = 1'b0;
    end
  endtask

  initial
  begin
    for (int k = 0; k < 5; k++)
    begin
      rstn = 1'b0;
      repeat (20) @(posedge sys_clk);
      #1;
      `CHK({cfg_loaded, units_rst_n, temp_unprotect_en}, 3'h0)
      rstn = 1'b1;
      load(k);
      `CHK({cfg_loaded, units_rst_n}, 2'h3)
      `CHK(slow_osc_cpu_allow, img[k][0][0])
      `CHK(indep_dog_hw_start, img[k][0][1])
      `CHK(window_dog_hw_start, img[k][0][2])
      `CHK({ext_clock_select, osc_output_pin_drive}, {img[k][1][3], ~img[k][1][3]})
      `CHK(autowake_clock_select, img[k][1][2])
      `CHK({autowake_prescale, autowake_divide}, {img[k][1][1:0], div_exp[k]})
      `CHK({crystal_settle_cycles, crystal_settle_half}, {cyc_exp[k], k == 0})
      `CHK(crystal_settle_code_ok, k != 4)
      `CHK({temp_unprotect_ctrl, temp_unprotect_en}, {img[k][3][3:0], k != 0})
      `CHK(flash_wait_state, img[k][4][0])
      `CHK(temp_unprotect_key, {img[k][8], img[k][7], img[k][6], img[k][5]})
      `CHK(temp_unprotect_key_ok, 1'b1)
      window_dog_active = (k != 4);
      halt_entry = 1'b1;
      @(posedge sys_clk);
      #1;
      halt_entry = 1'b0;
      window_dog_active = 1'b0;
      `CHK(halt_reset_req, img[k][0][3] & (k != 4))
      // stray storage answers after the load must not reload anything
      opt_data = ~img[k][0];
      opt_valid = 1'b1;
      repeat (4) @(posedge sys_clk);
      #1;
      opt_valid = 1'b0;
      `CHK({slow_osc_cpu_allow, window_dog_halt_reset}, {img[k][0][0], img[k][0][3]})
    end
    give_verdict;
  end

  initial
  begin
    #20000;
    n_mismatch++;
    give_verdict;
  end
endmodule
